//--- hdl/hv_measure_defs.svh
// Register offsets, field positions and reset values of the measurement path control
`ifndef HV_MEASURE_DEFS_SVH
`define HV_MEASURE_DEFS_SVH

`define MEAS_CTRL_OFS       12'h000
`define WAKE_PULL_OFS       12'h004
`define WAKE_CTRL2_OFS      12'h008
`define GP_CONFIG_OFS       12'h00c
`define MODE_CMD_OFS        12'h010
`define STATUS_OFS          12'h014
`define IRQ_STAT_OFS        12'h018
`define IRQ_MASK_OFS        12'h01c
`define LEVEL_STAT_OFS      12'h020

`define MEAS_EN_BIT         0
`define FAIL_TEST_BIT       1
`define WAKE_SRC_HV_BIT     0
`define WAKE_SRC_GP_BIT     1
`define WAKE_SRC_OTHER_BIT  2

`define GP_CONFIG_OFF       3'h0
`define GP_CONFIG_FAIL      3'h1
`define GP_CONFIG_WAKE      3'h2

`define IRQ_CMD_FAULT_BIT   0
`define IRQ_WAKE_HV_BIT     1
`define IRQ_WAKE_GP_BIT     2

`define GP_CONFIG_RESET     3'h1
`define WAKE_PULL_RESET     4'h0
`define WAKE_CTRL2_RESET    3'h1

`endif

//--- hdl/hv_measure_pkg.sv
// Types shared by the measurement path control
`default_nettype none
package hv_measure_pkg;

    typedef enum logic [2:0] {
        MODE_INIT      = 3'b000,
        MODE_NORMAL    = 3'b001,
        MODE_STOP      = 3'b010,
        MODE_SLEEP     = 3'b011,
        MODE_RESTART   = 3'b100,
        MODE_FAIL_SAFE = 3'b101
    } mode_type;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b10
    } bus_phase_type;

    typedef struct packed {
        logic [3:0] pull;
        logic [2:0] wake_ctrl;
        logic [2:0] gp_config;
    } pin_config_type;

    typedef struct packed {
        logic switch_closed;
        logic hv_pull_up;
        logic hv_pull_down;
        logic gp_pull_up;
        logic gp_pull_down;
        logic fail_drive;
        logic gp_wake_en;
        logic hv_wake_en;
    } pin_ctrl_type;

endpackage
`default_nettype wire

//--- hdl/hv_measure_path_control.sv
// High-voltage measurement path control with AHB-Lite register access
`include "hv_measure_defs.svh"
`default_nettype none

module hv_measure_path_control #(
    parameter int ADDR_WIDTH = 12,
    parameter int DATA_WIDTH = 32
) (
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    input  wire logic                     CE,
    input  wire logic                     HSEL,
    input  wire logic [ADDR_WIDTH-1:0]    HADDR,
    input  wire logic [1:0]               HTRANS,
    input  wire logic                     HWRITE,
    input  wire logic [2:0]               HSIZE,
    input  wire logic [DATA_WIDTH-1:0]    HWDATA,
    input  wire logic                     HREADY,
    output logic      [DATA_WIDTH-1:0]    HRDATA,
    output logic                          HREADYOUT,
    output logic                          HRESP,
    input  wire logic                     HV_WAKE_IN,
    input  wire logic                     GP_WAKE_IN,
    input  wire logic                     FAIL_EVENT,
    output logic                          IRQ,
    output hv_measure_pkg::mode_type      MODE,
    output hv_measure_pkg::pin_ctrl_type  PIN_CTRL
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        hv_measure_pkg::bus_phase_type  phase;
        logic [ADDR_WIDTH-1:0]          addr;
        logic [DATA_WIDTH-1:0]          rdata;
        hv_measure_pkg::mode_type       mode;
        logic                           measure_enable;
        logic                           fail_output_test;
        hv_measure_pkg::pin_config_type cfg;
        logic [2:0]                     wake_sources;
        logic [2:0]                     irq_stat;
        logic [2:0]                     irq_mask;
        logic [1:0]                     level_status;
        logic [1:0]                     last_level;
        hv_measure_pkg::pin_ctrl_type   pins;
        logic                           irq;
    } state_type;

    state_type state;
    state_type next_state;

    function automatic logic is_fail_config(input logic [2:0] c);
        is_fail_config = (c == `GP_CONFIG_FAIL);
    endfunction

    // Offsets are twelve bits; narrower buses keep the low part
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] ofs);
        hit = (a == ofs[ADDR_WIDTH-1:0]);
    endfunction

    // Codes above Fail-Safe name no mode, so such a command is dropped
    function automatic logic legal_mode(input logic [2:0] m);
        legal_mode = (m <= hv_measure_pkg::MODE_FAIL_SAFE);
    endfunction

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // Six bits reach the highest offset; fields are packed into one word
    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 12) begin
        $error("ADDR_WIDTH must lie between 6 and 12");
    end
    if (DATA_WIDTH != 32) begin
        $error("DATA_WIDTH must be 32");
    end

    logic                     write_now;
    logic                     fault;
    logic [2:0]               events;
    logic [1:0]               pin_level;
    hv_measure_pkg::mode_type req_mode;

    always_comb begin
        next_state = state;
        fault      = 1'b0;
        write_now  = (state.phase == hv_measure_pkg::BUS_WRITE);
        req_mode   = hv_measure_pkg::mode_type'(HWDATA[2:0]);
        pin_level  = {GP_WAKE_IN, HV_WAKE_IN};

        // ==========================================================
        // Bus slave: zero wait states
        // ==========================================================
        next_state.phase = hv_measure_pkg::BUS_IDLE;
        if (HSEL && HREADY && HTRANS[1]) begin
            next_state.phase = HWRITE ? hv_measure_pkg::BUS_WRITE : hv_measure_pkg::BUS_READ;
            next_state.addr  = HADDR;
        end

        if (write_now) begin
            if (hit(state.addr, `MEAS_CTRL_OFS)) begin
                if (HWDATA[`MEAS_EN_BIT] && !state.measure_enable
                        && state.cfg.gp_config != `GP_CONFIG_OFF) begin
                    fault = 1'b1;
                    next_state.measure_enable = 1'b0;
                end else begin
                    next_state.measure_enable = HWDATA[`MEAS_EN_BIT];
                end
                next_state.fail_output_test = HWDATA[`FAIL_TEST_BIT];
            end else if (hit(state.addr, `WAKE_PULL_OFS)) begin
                next_state.cfg.pull = HWDATA[3:0];
            end else if (hit(state.addr, `WAKE_CTRL2_OFS)) begin
                next_state.cfg.wake_ctrl = HWDATA[2:0];
                next_state.wake_sources  = HWDATA[2:0];
            end else if (hit(state.addr, `GP_CONFIG_OFS)) begin
                next_state.cfg.gp_config = HWDATA[2:0];
                if (state.measure_enable && HWDATA[2:0] != state.cfg.gp_config) begin
                    fault = 1'b1;
                end
            end else if (hit(state.addr, `MODE_CMD_OFS)) begin
                if (req_mode == hv_measure_pkg::MODE_SLEEP && state.measure_enable
                        && !state.wake_sources[`WAKE_SRC_OTHER_BIT]) begin
                    fault           = 1'b1;
                    next_state.mode = hv_measure_pkg::MODE_RESTART;
                end else if (legal_mode(HWDATA[2:0])) begin
                    next_state.mode = req_mode;
                end
            end else if (hit(state.addr, `IRQ_STAT_OFS)) begin
                next_state.irq_stat = state.irq_stat & ~HWDATA[2:0];
            end else if (hit(state.addr, `IRQ_MASK_OFS)) begin
                next_state.irq_mask = HWDATA[2:0];
            end
        end
        if (FAIL_EVENT) begin
            next_state.mode = hv_measure_pkg::MODE_FAIL_SAFE;
        end

        // ==========================================================
        // Wake detection, frozen while measuring
        // ==========================================================
        events = 3'h0;
        // Edge reference keeps tracking, so leaving measurement raises no false wake
        next_state.last_level = pin_level;
        if (!state.measure_enable) begin
            next_state.level_status = pin_level;
            events[`IRQ_WAKE_HV_BIT] = state.pins.hv_wake_en && (pin_level[0] != state.last_level[0]);
            events[`IRQ_WAKE_GP_BIT] = state.pins.gp_wake_en && (pin_level[1] != state.last_level[1]);
        end
        events[`IRQ_CMD_FAULT_BIT] = fault;
        // Set wins over a same-cycle clear
        next_state.irq_stat = next_state.irq_stat | events;
        next_state.irq      = |(next_state.irq_stat & next_state.irq_mask);

        // ==========================================================
        // Pin steering
        // ==========================================================
        if (next_state.measure_enable) begin
            next_state.pins               = '0;
            next_state.pins.switch_closed = (next_state.mode == hv_measure_pkg::MODE_NORMAL)
                                          && !is_fail_config(next_state.cfg.gp_config);
        end else begin
            next_state.pins.switch_closed = 1'b0;
            next_state.pins.hv_pull_up    = next_state.cfg.pull[0];
            next_state.pins.hv_pull_down  = next_state.cfg.pull[1];
            next_state.pins.gp_pull_up    = next_state.cfg.pull[2];
            next_state.pins.gp_pull_down  = next_state.cfg.pull[3];
            next_state.pins.fail_drive    = is_fail_config(next_state.cfg.gp_config)
                                          && (next_state.fail_output_test
                                              || next_state.mode == hv_measure_pkg::MODE_FAIL_SAFE);
            next_state.pins.hv_wake_en    = next_state.cfg.wake_ctrl[`WAKE_SRC_HV_BIT];
            next_state.pins.gp_wake_en    = (next_state.cfg.gp_config == `GP_CONFIG_WAKE)
                                          && next_state.cfg.wake_ctrl[`WAKE_SRC_GP_BIT];
        end

        // ==========================================================
        // Read data, answered in the data phase
        // ==========================================================
        next_state.rdata = '0;
        if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            if (hit(HADDR, `MEAS_CTRL_OFS)) begin
                next_state.rdata[1:0] = {state.fail_output_test, state.measure_enable};
            end else if (hit(HADDR, `WAKE_PULL_OFS)) begin
                next_state.rdata[3:0] = state.cfg.pull;
            end else if (hit(HADDR, `WAKE_CTRL2_OFS)) begin
                next_state.rdata[2:0] = state.cfg.wake_ctrl;
            end else if (hit(HADDR, `GP_CONFIG_OFS)) begin
                next_state.rdata[2:0] = state.cfg.gp_config;
            end else if (hit(HADDR, `MODE_CMD_OFS)) begin
                next_state.rdata[2:0] = state.mode;
            end else if (hit(HADDR, `STATUS_OFS)) begin
                next_state.rdata[7:0] = state.pins;
            end else if (hit(HADDR, `IRQ_STAT_OFS)) begin
                next_state.rdata[2:0] = state.irq_stat;
            end else if (hit(HADDR, `IRQ_MASK_OFS)) begin
                next_state.rdata[2:0] = state.irq_mask;
            end else if (hit(HADDR, `LEVEL_STAT_OFS)) begin
                next_state.rdata[1:0] = state.level_status;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state               <= '0;
            state.mode          <= hv_measure_pkg::MODE_INIT;
            state.cfg.pull      <= `WAKE_PULL_RESET;
            state.cfg.wake_ctrl <= `WAKE_CTRL2_RESET;
            state.cfg.gp_config <= `GP_CONFIG_RESET;
            state.wake_sources  <= `WAKE_CTRL2_RESET;
        end else if (CE) begin
            state <= next_state;
        end
    end

    assign HRDATA    = state.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign IRQ       = state.irq;
    assign MODE      = state.mode;
    assign PIN_CTRL  = state.pins;

endmodule
`default_nettype wire

//--- tb/hv_measure_pins.sv
// Pin-side model: sensed source and the general pin it loops into
`default_nettype none
module hv_measure_pins (
    input  wire logic [1:0] lvl,
    input  wire logic       switch_on,
    output logic            hv,
    output logic            gp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Closed switch makes the general pin follow the sensed input
    assign hv = lvl[0];
    assign gp = switch_on ? lvl[0] : lvl[1];
endmodule
`default_nettype wire

//--- tb/hv_measure_path_control_chk.sv
// Port checks of the measurement path control
`default_nettype none
module hv_measure_path_control_chk (
    input wire logic                         CLK,
    input wire logic                         RSTN,
    input wire logic                         CE,
    input wire logic                         HSEL,
    input wire logic [11:0]                  HADDR,
    input wire logic [1:0]                   HTRANS,
    input wire logic                         HWRITE,
    input wire logic                         HREADY,
    input wire logic [31:0]                  HRDATA,
    input wire logic                         HREADYOUT,
    input wire logic                         HRESP,
    input wire logic                         FAIL_EVENT,
    input wire hv_measure_pkg::mode_type     MODE,
    input wire hv_measure_pkg::pin_ctrl_type PIN_CTRL
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence read_taken;
        HSEL && HREADY && HTRANS[1] && !HWRITE && CE;
    endsequence
    sequence gap_read;
        read_taken ##0 (HADDR == 12'h030);
    endsequence
    reset_open_a: assert property ($rose(RSTN) |-> PIN_CTRL == 8'h00) else $error("pins not idle");
    switch_mode_a: assert property (PIN_CTRL.switch_closed |-> MODE == hv_measure_pkg::MODE_NORMAL)
        else $error("switch closed outside normal");
    pulls_off_a: assert property (PIN_CTRL.switch_closed |-> PIN_CTRL[6:3] == 4'h0) else $error("pull on");
    fail_off_a: assert property (PIN_CTRL.switch_closed |-> !PIN_CTRL.fail_drive) else $error("fail drive");
    wake_off_a: assert property (PIN_CTRL.switch_closed |-> !(PIN_CTRL.gp_wake_en || PIN_CTRL.hv_wake_en))
        else $error("wake enabled");
    bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or error");
    gap_read_a: assert property (gap_read |=> HRDATA == 32'h0) else $error("unmapped read not zero");
    idle_data_a: assert property (!(HSEL && HTRANS[1]) |=> HRDATA == 32'h0) else $error("stale read data");
    safe_entry_a: assert property (FAIL_EVENT && CE |-> ##[1:2] MODE == hv_measure_pkg::MODE_FAIL_SAFE)
        else $error("no fail-safe entry");
endmodule
bind hv_measure_path_control hv_measure_path_control_chk i_chk (.CLK, .RSTN, .CE, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .FAIL_EVENT, .MODE, .PIN_CTRL);
`default_nettype wire

//--- tb/hv_measure_path_control_bench.sv
// Self-checking bench of the measurement path control
`default_nettype none
`include "hv_measure_defs.svh"
module hv_measure_path_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clk, rstn, hsel, hwrite, fail_event, irq, hready, hresp, hv_in, gp_in;
    logic [11:0]                  haddr;
    logic [1:0]                   htrans, lvl;
    logic [31:0]                  hwdata, hrdata, seed, r;
    hv_measure_pkg::mode_type     mode;
    hv_measure_pkg::pin_ctrl_type pin;
    int                           error_cnt, checked;
    hv_measure_path_control i_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .HV_WAKE_IN(hv_in), .GP_WAKE_IN(gp_in), .FAIL_EVENT(fail_event),
        .IRQ(irq), .MODE(mode), .PIN_CTRL(pin));
    hv_measure_pins i_pins (.lvl(lvl), .switch_on(pin.switch_closed), .hv(hv_in), .gp(gp_in));
    task automatic close_out;
        $display("Counts: %0d errors, %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready and read data are taken at one rising edge, before the design updates them
    task automatic phase;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        r = hrdata;
        if (hready !== 1'b1) begin
            error_cnt++;
            close_out();
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        phase();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        phase();
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    function automatic logic [7:0] meas_pins(input hv_measure_pkg::mode_type m);
        return {m == hv_measure_pkg::MODE_NORMAL, 7'h0};
    endfunction
    // After reset: no pulls, no fail drive, only the sensed input may wake
    function automatic logic [7:0] reset_pins();
        logic [2:0] w;
        w = `WAKE_CTRL2_RESET;
        return {7'h0, w[`WAKE_SRC_HV_BIT]};
    endfunction
    task automatic look(input hv_measure_pkg::mode_type m);
        @(negedge clk);
        chk({24'h0, pin}, {24'h0, meas_pins(m)});
        chk({29'h0, mode}, {29'h0, m});
        @(posedge clk);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        {rstn, hsel, hwrite, fail_event, htrans, lvl, haddr, hwdata} = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({24'h0, pin}, {24'h0, reset_pins()});
        chk({29'h0, mode}, {29'h0, hv_measure_pkg::MODE_INIT});
        @(posedge clk);
        rd(`MEAS_CTRL_OFS, 32'h0);
        xfer(1'b1, `IRQ_MASK_OFS, 32'h1);
        for (int c = 1; c < 8; c++) begin
            xfer(1'b1, `GP_CONFIG_OFS, 32'(c));
            xfer(1'b1, `MEAS_CTRL_OFS, 32'h1);
            rd(`MEAS_CTRL_OFS, 32'h0);
            chk({31'h0, irq}, 32'h1);
            chk({31'h0, pin.switch_closed}, 32'h0);
            xfer(1'b1, `IRQ_STAT_OFS, 32'h7);
        end
        rd(12'h030, 32'h0);
        xfer(1'b1, `GP_CONFIG_OFS, 32'h0);
        xfer(1'b1, `MODE_CMD_OFS, 32'h1);
        xfer(1'b1, `MEAS_CTRL_OFS, 32'h1);
        look(hv_measure_pkg::MODE_NORMAL);
        seed = 32'h60bd5c7e;
        repeat (8) begin
            seed = lfsr(seed);
            lvl <= seed[5:4];
            xfer(1'b1, `WAKE_PULL_OFS, {28'h0, seed[3:0]});
            xfer(1'b1, `WAKE_CTRL2_OFS, {29'h0, seed[2:0]});
            xfer(1'b1, `MEAS_CTRL_OFS, {30'h0, seed[6], 1'b1});
            rd(`WAKE_PULL_OFS, {28'h0, seed[3:0]});
            look(hv_measure_pkg::MODE_NORMAL);
        end
        rd(`IRQ_STAT_OFS, 32'h0);
        rd(`LEVEL_STAT_OFS, 32'h0);
        xfer(1'b1, `GP_CONFIG_OFS, {29'h0, `GP_CONFIG_WAKE});
        rd(`IRQ_STAT_OFS, 32'h1);
        rd(`GP_CONFIG_OFS, {29'h0, `GP_CONFIG_WAKE});
        look(hv_measure_pkg::MODE_NORMAL);
        xfer(1'b1, `GP_CONFIG_OFS, {29'h0, `GP_CONFIG_FAIL});
        rd(`GP_CONFIG_OFS, {29'h0, `GP_CONFIG_FAIL});
        chk({31'h0, pin.switch_closed}, 32'h0);
        xfer(1'b1, `GP_CONFIG_OFS, {29'h0, `GP_CONFIG_WAKE});
        xfer(1'b1, `IRQ_STAT_OFS, 32'h7);
        xfer(1'b1, `MODE_CMD_OFS, 32'h2);
        look(hv_measure_pkg::MODE_STOP);
        xfer(1'b0, `MEAS_CTRL_OFS, 32'h0);
        chk({31'h0, r[0]}, 32'h1);
        xfer(1'b1, `MODE_CMD_OFS, 32'h1);
        xfer(1'b1, `WAKE_CTRL2_OFS, 32'h3);
        xfer(1'b1, `MODE_CMD_OFS, 32'h3);
        look(hv_measure_pkg::MODE_RESTART);
        rd(`IRQ_STAT_OFS, 32'h1);
        xfer(1'b1, `MODE_CMD_OFS, 32'h1);
        fail_event <= 1'b1;
        repeat (3) @(posedge clk);
        fail_event <= 1'b0;
        look(hv_measure_pkg::MODE_FAIL_SAFE);
        xfer(1'b0, `MEAS_CTRL_OFS, 32'h0);
        chk({31'h0, r[0]}, 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
